// ===== logic/strap_map.svh
// strap_map.svh: offsets, field positions and reset values for the strap decoder.
// assumes it is included by bare name from the package and the testbench.
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// vendor bank window loaded from the jack-compatibility strap
`define VBANK_FIRST 8'h13
`define VBANK_LAST 8'h1E
`define VBANK_COUNT 4'hC
`define VBANK_LAST_IDX 4'hB

// high bits of the management address above the three strapped bits
`define MGMT_ADDR_HIGH 2'h0
`define MGMT_BCAST_ADDR 5'h00

// function select codes
`define MODE_NAND_TREE 5'h04
`define MODE_DEV_PD 5'h07
`define MODE_SWPD_PLL_ON 5'h08
`define MODE_SWPD_PLL_OFF 5'h09
`define MODE_F1000_HOST 5'h0A
`define MODE_F100_FD 5'h0B
`define MODE_F100_HD 5'h0C
`define MODE_F1000_CLIENT 5'h0D
`define MODE_AN_RESERVED 5'h1E

// strap status word field positions
`define STS_MODE_LSB 0
`define STS_ADDR_LSB 5
`define STS_BCAST_BIT 8
`define STS_CLKOUT_BIT 9
`define STS_STYLE_BIT 10
`define STS_POL_LSB 11

// vendor bank data bases, values arbitrary
`define VBANK_STD_BASE 8'h80
`define VBANK_JACK_BASE 8'hC0

`endif

// ===== logic/strap_pkg.sv
// strap_pkg: types shared by the strap decoder and its vendor bank memory.
// assumes strap_map.svh is on the include path.
`include "strap_map.svh"

package strap_pkg;

	typedef enum logic [1:0] {
		S_SAMPLE = 2'b00,
		S_LOAD = 2'b01,
		S_DONE = 2'b10
	} load_state_e;

	typedef enum logic [1:0] {
		SPD_NONE = 2'b00,
		SPD_100 = 2'b01,
		SPD_1000 = 2'b10
	} force_speed_e;

	typedef struct packed {
		logic an_en;
		logic mdix_en;
		logic eee_en;
		logic adv_1000fd;
		logic multi_port;
		logic adv_100fd;
		logic adv_100hd;
		logic adv_10fd;
		logic adv_10hd;
		logic adv_pause;
		logic cat5;
		logic dev_pd;
		logic sw_pd;
		logic pll_off;
		logic nand_tree;
		logic forced;
		force_speed_e force_speed;
		logic force_fd;
		logic force_master;
		logic reserved;
	} mode_cfg_s;

	typedef logic [15:0] vbank_word_t;

endpackage

// ===== logic/vendor_bank_rom.sv
// vendor_bank_rom: twelve-word table of vendor bank defaults, two variants.
// assumes a synchronous read; the word appears one edge after the index.
`timescale 1ns/10ps

module vendor_bank_rom
	import strap_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] idx_i,
	input wire logic jack_i,
	output strap_pkg::vbank_word_t data_o
);

	// variant and index form the word; table values carry no meaning of their own
	function automatic vbank_word_t lookup(input logic jack, input logic [3:0] idx);
		logic [7:0] base;
		base = jack ? `VBANK_JACK_BASE : `VBANK_STD_BASE;
		lookup = {base, `VBANK_FIRST + {4'h0, idx}};
	endfunction

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_o <= 16'h0000;
		end else begin
			data_o <= lookup(jack_i, idx_i);
		end
	end

endmodule

// ===== logic/phy_strap_config_decode.sv
// phy_strap_config_decode: samples the board straps once after reset and turns them
// into management defaults, indicator setup, clock output gating and a vendor bank load.
// assumes straps are stable at reset release and synchronous to CLK_I.
//
// Behaviour
// - load vendor bank 13h-1Eh per jack strap
// - management address taken from three strap bits
// - broadcast enable default is inverted strap
// - broadcast enable also answers address zero
// - clock strap high drives reference clock out
// - reference clock defaults to local source
// - style strap high individual, low tri-colour
// - indicator polarity is inverse of its strap
// - polarities visible in strap status word
// - five-bit function strap decoded into mode
// - forced codes disable negotiation, crossover, EEE
// - gigabit half duplex never advertised
// - code 00111 powers down whole device
`timescale 1ns/10ps

module phy_strap_config_decode
	import strap_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	// strap inputs
	input wire logic [4:0] MODE_STRAP_I,
	input wire logic JACK_COMPAT_STRAP_I,
	input wire logic [2:0] MGMT_ADDR_STRAP_I,
	input wire logic BROADCAST_ADDR_STRAP_I,
	input wire logic REF_CLK_OUT_STRAP_I,
	input wire logic INDICATOR_STYLE_STRAP_I,
	input wire logic [4:0] INDICATOR_POLARITY_STRAP_I,
	// management address compare and broadcast control
	input wire logic [ADDR_W-1:0] MDIO_ADDR_I,
	input wire logic MDIO_ADDR_VALID_I,
	input wire logic BCAST_EN_WE_I,
	input wire logic BCAST_EN_WDATA_I,
	output logic ADDR_MATCH_O,
	output logic BROADCAST_ADDR_ENABLE_O,
	output logic [ADDR_W-1:0] MGMT_ADDR_O,
	// reference clock output
	input wire logic LOCAL_CLK_125_I,
	input wire logic RECOV_CLK_125_I,
	input wire logic REF_CLK_SRC_RECOV_I,
	output logic REF_CLK_OUT_PIN_O,
	// indicators and strap status
	output logic INDICATOR_INDIVIDUAL_O,
	output logic [4:0] INDICATOR_POL_O,
	output logic [15:0] STRAP_STATUS_O,
	// decoded mode
	output logic AN_EN_O,
	output logic AUTO_MDIX_O,
	output logic EEE_EN_O,
	output logic ADV_1000FD_O,
	output logic ADV_1000HD_O,
	output logic MULTI_PORT_O,
	output logic ADV_100FD_O,
	output logic ADV_100HD_O,
	output logic ADV_10FD_O,
	output logic ADV_10HD_O,
	output logic ADV_PAUSE_O,
	output logic ADV_EEE_1000_O,
	output logic ADV_EEE_100_O,
	output logic CAT5_10BT_O,
	output logic DEVICE_PD_O,
	output logic SW_PD_O,
	output logic PLL_OFF_O,
	output logic NAND_TREE_O,
	output logic FORCED_O,
	output strap_pkg::force_speed_e FORCE_SPEED_O,
	output logic FORCE_FD_O,
	output logic FORCE_MASTER_O,
	output logic MODE_RESERVED_O,
	// vendor bank write stream
	output logic VENDOR_WR_O,
	output logic [7:0] VENDOR_ADDR_O,
	output strap_pkg::vbank_word_t VENDOR_DATA_O,
	output logic CONFIG_DONE_O
);

	generate
		if (ADDR_W < 3) begin : g_bad_width
			$error("ADDR_W must hold the three strapped address bits");
		end
	endgenerate

	function automatic mode_cfg_s decode_mode(input logic [4:0] code);
		mode_cfg_s c;
		c = '0;
		c.force_speed = SPD_NONE;
		case (code)
			`MODE_NAND_TREE: c.nand_tree = 1'b1;
			`MODE_DEV_PD: c.dev_pd = 1'b1;
			`MODE_SWPD_PLL_ON: c.sw_pd = 1'b1;
			`MODE_SWPD_PLL_OFF: begin
				c.sw_pd = 1'b1;
				c.pll_off = 1'b1;
			end
			// negotiation, crossover and EEE stay cleared in forced codes
			`MODE_F1000_HOST, `MODE_F1000_CLIENT: begin
				c.forced = 1'b1;
				c.force_speed = SPD_1000;
				c.force_fd = 1'b1;
				c.force_master = (code == `MODE_F1000_HOST);
			end
			`MODE_F100_FD, `MODE_F100_HD: begin
				c.forced = 1'b1;
				c.force_speed = SPD_100;
				c.force_fd = (code == `MODE_F100_FD);
			end
			`MODE_AN_RESERVED: c.reserved = 1'b1;
			default: begin
				if (code[4]) begin
					// bit 3 picks the EEE and cat5 set of the negotiated codes
					c.an_en = 1'b1;
					c.mdix_en = 1'b1;
					c.adv_pause = 1'b1;
					c.eee_en = code[3];
					c.cat5 = code[3];
					c.multi_port = code[0] & ~code[2];
					c.adv_1000fd = ~code[2];
					c.adv_100fd = (code[2:0] != 3'h2) && (code[2:0] != 3'h3)
						&& (code[2:0] != 3'h6);
					c.adv_100hd = (code[2:1] == 2'h0) || (code[2:0] == 3'h4)
						|| (code[2:1] == 2'h3);
					c.adv_10fd = (code[2:1] == 2'h0) || (code[2:0] == 3'h7);
					c.adv_10hd = c.adv_10fd;
				end else begin
					c.reserved = 1'b1;
				end
			end
		endcase
		decode_mode = c;
	endfunction

	load_state_e state;
	logic [3:0] load_idx;
	logic [3:0] wr_idx;
	logic wr_pend;
	mode_cfg_s cfg;
	logic [4:0] mode_lat;
	logic jack_lat;
	logic [2:0] addr_lat;
	logic bcast_strap_lat;
	logic clkout_lat;
	logic style_lat;
	logic [4:0] pol_lat;
	logic bcast_en;
	vbank_word_t rom_data;

	wire sample = (state == S_SAMPLE);
	wire [ADDR_W-1:0] own_addr = {{(ADDR_W-3){1'b0}}, addr_lat}
		| ({{(ADDR_W-2){1'b0}}, `MGMT_ADDR_HIGH} << 3);
	wire hit_own = (MDIO_ADDR_I == own_addr);
	wire hit_bcast = bcast_en && (MDIO_ADDR_I == `MGMT_BCAST_ADDR);
	wire ref_clk_sel = REF_CLK_SRC_RECOV_I ? RECOV_CLK_125_I : LOCAL_CLK_125_I;

	// straps are caught once by a clocked process after release, never by the reset itself
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			mode_lat <= 5'h00;
			jack_lat <= 1'b0;
			addr_lat <= 3'h0;
			bcast_strap_lat <= 1'b1;
			clkout_lat <= 1'b0;
			style_lat <= 1'b0;
			pol_lat <= 5'h00;
			cfg <= '0;
		end else if (sample) begin
			mode_lat <= MODE_STRAP_I;
			jack_lat <= JACK_COMPAT_STRAP_I;
			addr_lat <= MGMT_ADDR_STRAP_I;
			bcast_strap_lat <= BROADCAST_ADDR_STRAP_I;
			clkout_lat <= REF_CLK_OUT_STRAP_I;
			style_lat <= INDICATOR_STYLE_STRAP_I;
			pol_lat <= INDICATOR_POLARITY_STRAP_I;
			cfg <= decode_mode(MODE_STRAP_I);
		end
	end

	// software may rewrite the bit once the default is in place
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			bcast_en <= 1'b0;
		end else if (sample) begin
			bcast_en <= ~BROADCAST_ADDR_STRAP_I;
		end else if (BCAST_EN_WE_I) begin
			bcast_en <= BCAST_EN_WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state <= S_SAMPLE;
			load_idx <= 4'h0;
			wr_idx <= 4'h0;
			wr_pend <= 1'b0;
		end else begin
			case (state)
				S_SAMPLE: begin
					state <= S_LOAD;
					load_idx <= 4'h0;
				end
				S_LOAD: begin
					wr_pend <= 1'b1;
					wr_idx <= load_idx;
					if (load_idx == `VBANK_LAST_IDX) begin
						state <= S_DONE;
					end else begin
						load_idx <= load_idx + 4'h1;
					end
				end
				S_DONE: wr_pend <= 1'b0;
				default: state <= S_SAMPLE;
			endcase
		end
	end

	vendor_bank_rom u_rom (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.idx_i(load_idx),
		.jack_i(jack_lat),
		.data_o(rom_data)
	);

	assign VENDOR_WR_O = wr_pend;
	assign VENDOR_ADDR_O = `VBANK_FIRST + {4'h0, wr_idx};
	assign VENDOR_DATA_O = rom_data;
	assign CONFIG_DONE_O = (state == S_DONE) && !wr_pend;

	assign ADDR_MATCH_O = MDIO_ADDR_VALID_I && !sample && (hit_own || hit_bcast);
	assign BROADCAST_ADDR_ENABLE_O = bcast_en;
	assign MGMT_ADDR_O = own_addr;

	// gated combinationally: the pin is low whenever the strap was low
	assign REF_CLK_OUT_PIN_O = clkout_lat & ref_clk_sel;

	assign INDICATOR_INDIVIDUAL_O = style_lat;
	assign INDICATOR_POL_O = ~pol_lat;
	assign STRAP_STATUS_O = ({11'h000, mode_lat} << `STS_MODE_LSB)
		| ({13'h0000, addr_lat} << `STS_ADDR_LSB)
		| ({15'h0000, bcast_strap_lat} << `STS_BCAST_BIT)
		| ({15'h0000, clkout_lat} << `STS_CLKOUT_BIT)
		| ({15'h0000, style_lat} << `STS_STYLE_BIT)
		| ({11'h000, ~pol_lat} << `STS_POL_LSB);

	assign AN_EN_O = cfg.an_en;
	assign AUTO_MDIX_O = cfg.mdix_en;
	assign EEE_EN_O = cfg.eee_en;
	assign ADV_1000FD_O = cfg.adv_1000fd;
	assign ADV_1000HD_O = 1'b0;
	assign MULTI_PORT_O = cfg.multi_port;
	assign ADV_100FD_O = cfg.adv_100fd;
	assign ADV_100HD_O = cfg.adv_100hd;
	assign ADV_10FD_O = cfg.adv_10fd;
	assign ADV_10HD_O = cfg.adv_10hd;
	assign ADV_PAUSE_O = cfg.adv_pause;
	assign ADV_EEE_1000_O = cfg.eee_en & cfg.adv_1000fd;
	assign ADV_EEE_100_O = cfg.eee_en & (cfg.adv_100fd | cfg.adv_100hd);
	assign CAT5_10BT_O = cfg.cat5;
	assign DEVICE_PD_O = cfg.dev_pd;
	assign SW_PD_O = cfg.sw_pd;
	assign PLL_OFF_O = cfg.pll_off;
	assign NAND_TREE_O = cfg.nand_tree;
	assign FORCED_O = cfg.forced;
	assign FORCE_SPEED_O = cfg.force_speed;
	assign FORCE_FD_O = cfg.force_fd;
	assign FORCE_MASTER_O = cfg.force_master;
	assign MODE_RESERVED_O = cfg.reserved;

endmodule

// ===== test/strap_asserts.sv
// strap_asserts: port-level checks on the strap decoder.
// assumes it is bound to phy_strap_config_decode, one clock domain.
`timescale 1ns/10ps
module strap_asserts #(
	parameter int ADDR_W = 5
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [ADDR_W-1:0] MDIO_ADDR_I,
	input wire logic MDIO_ADDR_VALID_I,
	input wire logic ADDR_MATCH_O,
	input wire logic BROADCAST_ADDR_ENABLE_O,
	input wire logic REF_CLK_OUT_PIN_O,
	input wire logic [4:0] INDICATOR_POL_O,
	input wire logic [15:0] STRAP_STATUS_O,
	input wire logic AN_EN_O,
	input wire logic AUTO_MDIX_O,
	input wire logic EEE_EN_O,
	input wire logic ADV_1000HD_O,
	input wire logic ADV_PAUSE_O,
	input wire logic DEVICE_PD_O,
	input wire logic FORCED_O,
	input wire logic VENDOR_WR_O,
	input wire logic [7:0] VENDOR_ADDR_O,
	input wire logic CONFIG_DONE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	wire [4:0] code = STRAP_STATUS_O[4:0];
	sequence burst_s;
		VENDOR_WR_O[*6] ##1 VENDOR_WR_O[*6] ##1 (!VENDOR_WR_O && CONFIG_DONE_O);
	endsequence
	a_vendor_burst: assert property ($rose(VENDOR_WR_O) |-> burst_s)
		else $error("vendor load is not twelve back-to-back words");
	a_vendor_step: assert property (VENDOR_WR_O && $past(VENDOR_WR_O) |->
		VENDOR_ADDR_O == $past(VENDOR_ADDR_O) + 8'h01) else $error("vendor address skipped");
	a_bcast_zero: assert property (MDIO_ADDR_VALID_I && BROADCAST_ADDR_ENABLE_O &&
		MDIO_ADDR_I == '0 && CONFIG_DONE_O |-> ADDR_MATCH_O) else $error("address zero ignored");
	a_clk_gate: assert property (!STRAP_STATUS_O[9] |-> !REF_CLK_OUT_PIN_O)
		else $error("clock out while disabled");
	a_pol_status: assert property (INDICATOR_POL_O == STRAP_STATUS_O[15:11])
		else $error("status polarity differs");
	a_forced_quiet: assert property (CONFIG_DONE_O && code inside {[5'h0A:5'h0D]} |->
		FORCED_O && !(AN_EN_O || AUTO_MDIX_O || EEE_EN_O)) else $error("forced mode wrong");
	a_hd_never: assert property (!ADV_1000HD_O)
		else $error("gigabit half duplex advertised");
	a_pd_mode: assert property (CONFIG_DONE_O && code == 5'h07 |-> DEVICE_PD_O)
		else $error("power down missing");
	a_neg_set: assert property (CONFIG_DONE_O && code[4:3] == 2'h3 && code != 5'h1E |->
		AN_EN_O && AUTO_MDIX_O && ADV_PAUSE_O && EEE_EN_O) else $error("negotiation set wrong");
endmodule
bind phy_strap_config_decode strap_asserts #(.ADDR_W(ADDR_W)) strap_asserts_i (.*);

// ===== test/board_straps.sv
// board_straps: the board resistors on the strap pins.
// assumes the bench picks each resistor: 1 pull-up, 0 pull-down.
`timescale 1ns/10ps
module board_straps (
	input wire logic [16:0] PULL_I,
	output logic [4:0] MODE_STRAP_I,
	output logic JACK_COMPAT_STRAP_I,
	output logic [2:0] MGMT_ADDR_STRAP_I,
	output logic BROADCAST_ADDR_STRAP_I,
	output logic REF_CLK_OUT_STRAP_I,
	output logic INDICATOR_STYLE_STRAP_I,
	output logic [4:0] INDICATOR_POLARITY_STRAP_I
);
	// resistors never release, so each pin always shows its pull level
	assign {MODE_STRAP_I, JACK_COMPAT_STRAP_I, MGMT_ADDR_STRAP_I, BROADCAST_ADDR_STRAP_I,
		REF_CLK_OUT_STRAP_I, INDICATOR_STYLE_STRAP_I, INDICATOR_POLARITY_STRAP_I} = PULL_I;
endmodule

// ===== test/tb.sv
// tb: boots the strap decoder under many strap settings and checks the defaults.
// assumes board_straps and the bound checker are compiled first.
`timescale 1ns/10ps
`include "strap_map.svh"
module tb;
	import strap_pkg::*;
	logic CLK_I = 0, NRST_I = 0, MDIO_ADDR_VALID_I = 0, BCAST_EN_WE_I = 0, BCAST_EN_WDATA_I = 0;
	logic LOCAL_CLK_125_I = 0, REF_CLK_SRC_RECOV_I = 0;
	logic [4:0] MDIO_ADDR_I = 0, MODE_STRAP_I, INDICATOR_POLARITY_STRAP_I, INDICATOR_POL_O;
	logic [16:0] PULL_I = 0;
	wire RECOV_CLK_125_I = ~LOCAL_CLK_125_I;
	logic [2:0] MGMT_ADDR_STRAP_I;
	logic JACK_COMPAT_STRAP_I, BROADCAST_ADDR_STRAP_I, REF_CLK_OUT_STRAP_I;
	logic INDICATOR_STYLE_STRAP_I, ADDR_MATCH_O, BROADCAST_ADDR_ENABLE_O, REF_CLK_OUT_PIN_O;
	logic INDICATOR_INDIVIDUAL_O, AN_EN_O, AUTO_MDIX_O, EEE_EN_O, ADV_1000FD_O, ADV_1000HD_O;
	logic MULTI_PORT_O, ADV_100FD_O, ADV_100HD_O, ADV_10FD_O, ADV_10HD_O, ADV_PAUSE_O;
	logic ADV_EEE_1000_O, ADV_EEE_100_O, CAT5_10BT_O, DEVICE_PD_O, SW_PD_O, PLL_OFF_O;
	logic NAND_TREE_O, FORCED_O, FORCE_FD_O, FORCE_MASTER_O, MODE_RESERVED_O, VENDOR_WR_O;
	logic CONFIG_DONE_O;
	logic [4:0] MGMT_ADDR_O;
	logic [15:0] STRAP_STATUS_O, VENDOR_DATA_O;
	logic [7:0] VENDOR_ADDR_O;
	force_speed_e FORCE_SPEED_O;
	wire [5:0] adv = {ADV_1000FD_O, MULTI_PORT_O, ADV_100FD_O, ADV_100HD_O, ADV_10FD_O, ADV_10HD_O};
	// speed and duplex set of each negotiated code, indexed by its low three bits
	logic [5:0] adv_tab [8] = '{6'h2F, 6'h3F, 6'h20, 6'h30, 6'h0C, 6'h08, 6'h04, 6'h0F};
	int fails = 0, num_checks = 0, cyc = 0;
	board_straps board_straps_i (.*);
	phy_strap_config_decode phy_strap_config_decode_i (.*);
	initial begin
		forever #20 CLK_I = ~CLK_I;
	end
	always #4 LOCAL_CLK_125_I = ~LOCAL_CLK_125_I;
	task automatic summarize();
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic boot(input logic [16:0] pull);
		int n, k;
		logic [7:0] a;
		n = 0;
		k = 0;
		@(negedge CLK_I);
		NRST_I = 0;
		PULL_I = pull;
		repeat (2) @(negedge CLK_I);
		NRST_I = 1;
		while (CONFIG_DONE_O !== 1'h1 && k < 20) begin
			@(negedge CLK_I);
			k++;
			a = 8'(`VBANK_FIRST + n);
			if (VENDOR_WR_O === 1'h1) begin
				cmp(VENDOR_ADDR_O, a);
				cmp(VENDOR_DATA_O, {pull[11] ? `VBANK_JACK_BASE : `VBANK_STD_BASE, a});
				n++;
			end
		end
		cmp(n, `VBANK_COUNT);
	endtask
	task automatic probe(input logic [4:0] a, input logic m);
		MDIO_ADDR_I = a;
		MDIO_ADDR_VALID_I = 1;
		#1;
		cmp(ADDR_MATCH_O, m);
		@(negedge CLK_I);
	endtask
	task automatic clk_out(input logic on, input logic recov);
		#2;
		repeat (4) begin
			cmp(REF_CLK_OUT_PIN_O, on & (recov ? RECOV_CLK_125_I : LOCAL_CLK_125_I));
			#4;
		end
		// hand back on a falling edge so the next stimulus keeps to it
		@(negedge CLK_I);
	endtask
	task automatic t_defaults();
		boot({5'h18, 1'h0, 3'h5, 1'h1, 1'h1, 1'h1, 5'h0A});
		clk_out(1, 0);
		REF_CLK_SRC_RECOV_I = 1;
		clk_out(1, 1);
		REF_CLK_SRC_RECOV_I = 0;
		cmp(STRAP_STATUS_O[10:5], 6'h3D);
		cmp(MGMT_ADDR_O, 5'h05);
		cmp(BROADCAST_ADDR_ENABLE_O, 0);
		cmp({INDICATOR_INDIVIDUAL_O, INDICATOR_POL_O}, 6'h35);
		cmp(STRAP_STATUS_O[15:11], 5'h15);
		probe(5'h05, 1);
		probe(5'h06, 0);
		probe(5'h00, 0);
		boot({5'h18, 1'h1, 3'h2, 1'h0, 1'h0, 1'h0, 5'h15});
		clk_out(0, 0);
		cmp(STRAP_STATUS_O[10:5], 6'h02);
		cmp(BROADCAST_ADDR_ENABLE_O, 1);
		cmp({INDICATOR_INDIVIDUAL_O, INDICATOR_POL_O}, 6'h0A);
		probe(5'h00, 1);
		probe(5'h02, 1);
		PULL_I = 17'h1FFFF;
		BCAST_EN_WE_I = 1;
		@(negedge CLK_I);
		BCAST_EN_WE_I = 0;
		probe(5'h00, 0);
		cmp({MGMT_ADDR_O, INDICATOR_POL_O, STRAP_STATUS_O[4:0]}, 15'h0958);
	endtask
	task automatic t_modes();
		logic [4:0] c;
		logic [5:0] row;
		logic e;
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			boot({c, i[0], 3'h1, 1'h1, 1'h0, 1'h1, 5'h00});
			row = (c[4] && c != 5'h1E) ? adv_tab[c[2:0]] : 6'h00;
			e = c[4] & c[3] & (c != 5'h1E);
			cmp(adv, row);
			cmp({ADV_EEE_1000_O, ADV_EEE_100_O, CAT5_10BT_O}, {e & row[5], e & |row[3:2], e});
			cmp({NAND_TREE_O, SW_PD_O, PLL_OFF_O}, {c == 4, c inside {8, 9}, c == 9});
			cmp(FORCE_SPEED_O, {c inside {10, 13}, c inside {11, 12}});
			cmp({FORCE_FD_O, FORCE_MASTER_O}, {c inside {10, 11, 13}, c == 10});
			cmp(STRAP_STATUS_O[4:0], c);
			cmp(MODE_RESERVED_O, c inside {[0:3], 5, 6, 14, 15, 30});
			cmp(ADV_1000HD_O, 0);
			cmp(DEVICE_PD_O, c == 5'h07);
			cmp(FORCED_O, c inside {[5'h0A:5'h0D]});
			if (c inside {[5'h0A:5'h0D]})
				cmp({AN_EN_O, AUTO_MDIX_O, EEE_EN_O}, 3'h0);
			if (c[4] && c != 5'h1E)
				cmp({AN_EN_O, AUTO_MDIX_O, ADV_PAUSE_O, EEE_EN_O}, {3'h7, c[3]});
		end
	endtask
	initial begin
		t_defaults();
		t_modes();
		summarize();
	end
endmodule
